// ### hdl/gpls_port.v
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gpls_consts.vh"
module gpls_port
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [31:0] pad_in,
  output wire [31:0] pad_out,
  output wire [31:0] pad_oe,
  input wire [31:0] periph_own,
  input wire [31:0] periph_out,
  input wire [31:0] periph_oe,
  output wire [31:0] periph_in,
  output wire nonsecure_port_hit,
  output wire secure_port_hit,
  output wire wake_hit
);

  // Loop indices, one per process so no variable has two drivers
  integer k;
  integer m;
  integer j;
  reg [31:0] out_r;
  reg [31:0] dir_r;
  reg [31:0] capture_r;
  reg [31:0] secure_r;
  reg nonsecure_hit_source_select_r;
  reg secure_hit_source_select_r;
  reg [31:0] pin_config [0:31];
  reg [31:0] sync1_r;
  reg [31:0] sync2_r;
  reg [31:0] hit_d_r;
  reg [31:0] prdata_r;
  reg clr_pulse_r;
  reg ns_relatch_r;
  reg s_relatch_r;
  reg [31:0] in_conn;
  reg [31:0] pin_hit;
  reg [31:0] capture_nxt;
  reg [31:0] rd_nxt;
  reg [31:0] cap_set;
  reg [31:0] cap_clr;
  reg ns_port_hit;
  reg s_port_hit;
  wire wr_en;
  wire cap_clr_wr;
  wire rd_en;
  wire [11:0] cfg_off;
  wire [4:0] cfg_idx;
  wire addr_ok;

  // Pin hit from its config word and the synchronised level
  function hit_of;
    input [31:0] cfg;
    input lvl;
    begin
      hit_of = 1'b0;
      if (!cfg[`GPLS_CFG_INDIS])
      begin
        if (cfg[`GPLS_CFG_SENSE_HI:`GPLS_CFG_SENSE_LO] == `GPLS_SENSE_HIGH)
          hit_of = lvl;
        else if (cfg[`GPLS_CFG_SENSE_HI:`GPLS_CFG_SENSE_LO] == `GPLS_SENSE_LOW)
          hit_of = ~lvl;
      end
    end
  endfunction

  // Config window test, shared by decode, read mux and write path;
  // a misaligned address inside the window is refused, not aliased
  function is_cfg_addr;
    input [11:0] a;
    begin
      is_cfg_addr = (a[1:0] == 2'h0) &&
                    (a >= `GPLS_OFF_CFG_BASE) &&
                    (a <= `GPLS_OFF_CFG_LAST);
    end
  endfunction

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign cfg_off = paddr - `GPLS_OFF_CFG_BASE;
  assign cfg_idx = cfg_off[6:2];
  assign cap_clr_wr = wr_en && (paddr == `GPLS_OFF_CAPTURE);
  assign addr_ok = ((paddr[1:0] == 2'h0) &&
                    (paddr >= `GPLS_OFF_OUT) &&
                    (paddr <= `GPLS_OFF_SECURE)) ||
                   is_cfg_addr(paddr);
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_r;

  // Two flops on the pads; only the second one is looked at
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 32'h00000000;
      sync2_r <= 32'h00000000;
    end
    else
    begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
    end
  end

  // Input value seen by software and peripherals; a disconnected
  // buffer reads low rather than a stale level
  always @*
  begin
    in_conn = 32'h00000000;
    for (k = 0; k < `GPLS_NPINS; k = k + 1)
    begin
      in_conn[k] = sync2_r[k] & ~pin_config[k][`GPLS_CFG_INDIS];
    end
  end

  // Per-pin hit, purely combinational so an enable acts at once;
  // in direct mode no flop sits between the synchroniser and the event unit
  always @*
  begin
    pin_hit = 32'h00000000;
    for (m = 0; m < `GPLS_NPINS; m = m + 1)
    begin
      pin_hit[m] = hit_of(pin_config[m], sync2_r[m]);
    end
  end

  // Capture flags: a rising hit beats a clear in the same cycle,
  // so an event landing on the clear write is never lost
  always @*
  begin
    cap_set = pin_hit & ~hit_d_r;
    cap_clr = 32'h00000000;
    if (cap_clr_wr)
      cap_clr = pwdata & ~pin_hit;
    capture_nxt = (capture_r & ~cap_clr) | cap_set;
  end

  // Read mux; unmapped and misaligned addresses read zero
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (paddr)
      `GPLS_OFF_OUT, `GPLS_OFF_OUTSET, `GPLS_OFF_OUTCLR: rd_nxt = out_r;
      `GPLS_OFF_IN: rd_nxt = in_conn;
      `GPLS_OFF_DIR, `GPLS_OFF_DIRSET, `GPLS_OFF_DIRCLR: rd_nxt = dir_r;
      `GPLS_OFF_CAPTURE: rd_nxt = capture_r;
      `GPLS_OFF_NSMODE: rd_nxt = {31'h00000000, nonsecure_hit_source_select_r};
      `GPLS_OFF_SMODE: rd_nxt = {31'h00000000, secure_hit_source_select_r};
      `GPLS_OFF_SECURE: rd_nxt = secure_r;
      default:
      begin
        if (is_cfg_addr(paddr))
          rd_nxt = pin_config[cfg_idx];
      end
    endcase
  end

  // Read data is loaded in the setup cycle and stands until the
  // next read setup, so the access cycle needs no wait state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
    end
    else if (rd_en)
    begin
      prdata_r <= rd_nxt;
    end
  end

  // Output latch; set and clear aliases act on the same word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_r <= 32'h00000000;
    end
    else if (wr_en)
    begin
      case (paddr)
        `GPLS_OFF_OUT: out_r <= pwdata;
        `GPLS_OFF_OUTSET: out_r <= out_r | pwdata;
        `GPLS_OFF_OUTCLR: out_r <= out_r & ~pwdata;
        default: out_r <= out_r;
      endcase
    end
  end

  // Direction latch; a one drives the pad unless a peripheral owns it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_r <= 32'h00000000;
    end
    else if (wr_en)
    begin
      case (paddr)
        `GPLS_OFF_DIR: dir_r <= pwdata;
        `GPLS_OFF_DIRSET: dir_r <= dir_r | pwdata;
        `GPLS_OFF_DIRCLR: dir_r <= dir_r & ~pwdata;
        default: dir_r <= dir_r;
      endcase
    end
  end

  // Security class per pin; a one marks the pin secure. The bus has
  // no security attribute, so any access may change the split
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      secure_r <= 32'h00000000;
    end
    else if (wr_en && paddr == `GPLS_OFF_SECURE)
    begin
      secure_r <= pwdata;
    end
  end

  // Hit source selects, one per security class
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nonsecure_hit_source_select_r <= `GPLS_MODE_DIRECT;
      secure_hit_source_select_r <= `GPLS_MODE_DIRECT;
    end
    else if (wr_en)
    begin
      if (paddr == `GPLS_OFF_NSMODE)
        nonsecure_hit_source_select_r <= pwdata[0];
      if (paddr == `GPLS_OFF_SMODE)
        secure_hit_source_select_r <= pwdata[0];
    end
  end

  // Pin configuration words; unused fields are dropped on write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (j = 0; j < `GPLS_NPINS; j = j + 1)
        pin_config[j] <= `GPLS_CFG_RESET;
    end
    else if (wr_en && is_cfg_addr(paddr))
    begin
      pin_config[cfg_idx] <= pwdata & `GPLS_CFG_MASK;
    end
  end

  // Capture state and the hit history used to find rising hits;
  // the clear pulse marks a capture write that carried any one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hit_d_r <= 32'h00000000;
      capture_r <= 32'h00000000;
      clr_pulse_r <= 1'b0;
    end
    else
    begin
      hit_d_r <= pin_hit;
      capture_r <= capture_nxt;
      clr_pulse_r <= cap_clr_wr && (pwdata != 32'h00000000);
    end
  end

  // Non-secure latched level, one cycle behind the flags so a clear
  // write can punch a one-cycle hole before the level returns
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ns_relatch_r <= 1'b0;
    end
    else
    begin
      ns_relatch_r <= |(capture_r & ~secure_r);
    end
  end

  // Secure latched level, same timing as the non-secure one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_relatch_r <= 1'b0;
    end
    else
    begin
      s_relatch_r <= |(capture_r & secure_r);
    end
  end

  // The hole hits both classes; a spare edge on the other class is
  // the price of a single clear strobe
  wire ns_latched_sense_hit = ns_relatch_r & ~clr_pulse_r;
  wire s_latched_sense_hit = s_relatch_r & ~clr_pulse_r;
  wire ns_direct = |(pin_hit & ~secure_r);
  wire s_direct = |(pin_hit & secure_r);

  // Non-secure source selection; live with no bus traffic at all
  always @*
  begin
    if (nonsecure_hit_source_select_r == `GPLS_MODE_LATCHED)
      ns_port_hit = ns_latched_sense_hit;
    else
      ns_port_hit = ns_direct;
  end

  // Secure source selection, independent of the non-secure one
  always @*
  begin
    if (secure_hit_source_select_r == `GPLS_MODE_LATCHED)
      s_port_hit = s_latched_sense_hit;
    else
      s_port_hit = s_direct;
  end

  // Class hits go to their own event units; either one may wake
  assign nonsecure_port_hit = ns_port_hit;
  assign secure_port_hit = s_port_hit;
  assign wake_hit = nonsecure_port_hit | secure_port_hit;

  // Peripheral override of drive; inputs shared with peripherals
  assign pad_out = (periph_own & periph_out) | (~periph_own & out_r);
  assign pad_oe = (periph_own & periph_oe) | (~periph_own & dir_r);
  assign periph_in = in_conn;

endmodule

// ### include/gpls_consts.vh
`ifndef GPLS_CONSTS_VH
`define GPLS_CONSTS_VH
// Register byte offsets
`define GPLS_OFF_OUT 12'h004
`define GPLS_OFF_OUTSET 12'h008
`define GPLS_OFF_OUTCLR 12'h00C
`define GPLS_OFF_IN 12'h010
`define GPLS_OFF_DIR 12'h014
`define GPLS_OFF_DIRSET 12'h018
`define GPLS_OFF_DIRCLR 12'h01C
`define GPLS_OFF_CAPTURE 12'h020
`define GPLS_OFF_NSMODE 12'h024
`define GPLS_OFF_SMODE 12'h028
`define GPLS_OFF_SECURE 12'h02C
`define GPLS_OFF_CFG_BASE 12'h200
`define GPLS_OFF_CFG_LAST 12'h27C
// Pin config fields
`define GPLS_CFG_DIR 0
`define GPLS_CFG_INDIS 1
`define GPLS_CFG_SENSE_LO 16
`define GPLS_CFG_SENSE_HI 17
`define GPLS_CFG_MASK 32'h00030003
`define GPLS_CFG_RESET 32'h00000002
// Sense field encodings
`define GPLS_SENSE_OFF 2'h0
`define GPLS_SENSE_HIGH 2'h2
`define GPLS_SENSE_LOW 2'h3
// Hit source select values
`define GPLS_MODE_DIRECT 1'b0
`define GPLS_MODE_LATCHED 1'b1
`define GPLS_NPINS 32
`endif

// ### test/gpls_pads.sv
`timescale 1ns/1ps
module gpls_pads (
  input wire pclk,
  input wire [31:0] level,
  input wire [31:0] pad_out,
  input wire [31:0] pad_oe,
  output logic [31:0] pad_in = 32'h0
);
  // Driven pins read back their driver; free pins follow the outside level
  always @(posedge pclk)
    pad_in <= (pad_oe & pad_out) | (~pad_oe & level);
endmodule

// ### test/gpls_port_props.sv
`timescale 1ns/1ps
module gpls_port_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire [31:0] pad_in,
  input wire [31:0] pad_oe,
  input wire [31:0] periph_own,
  input wire [31:0] periph_oe,
  input wire [31:0] periph_in,
  input wire nonsecure_port_hit,
  input wire secure_port_hit,
  input wire wake_hit
);
  logic mode_r;
  wire acc = psel && penable;
  wire cap_wr = acc && pwrite && paddr == 12'h020 && pwdata != 32'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the non-secure select; the clear gap exists only when latched
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      mode_r <= 1'b0;
    else if (acc && pwrite && paddr == 12'h024)
      mode_r <= pwdata[0];
  // Port checks
  a_in_delay: assert property ((periph_in & ~$past(pad_in, 2)) == 32'h0)
    else $error("input ahead of pad");
  a_own_oe: assert property (((pad_oe ^ periph_oe) & periph_own) == 32'h0)
    else $error("override enable lost");
  a_wake_or: assert property (wake_hit == (nonsecure_port_hit || secure_port_hit))
    else $error("wake differs from port hits");
  a_latch_gap: assert property (cap_wr && mode_r |=> !nonsecure_port_hit)
    else $error("no gap after clear");
  a_cfg_ok: assert property (acc && paddr[11:7] == 5'h04 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("config refused");
  a_cap_ok: assert property (acc && paddr == 12'h020 |-> !pslverr)
    else $error("capture refused");
  a_mode_ok: assert property (acc && (paddr == 12'h024 || paddr == 12'h028) |-> !pslverr)
    else $error("source select refused");
  a_rise_cause: assert property ($rose(nonsecure_port_hit) && !mode_r |->
    $past(pad_in, 2) != $past(pad_in, 3) || $past(acc && pwrite))
    else $error("hit rose without cause");
  c_ns_hit: cover property ($rose(nonsecure_port_hit));
  c_s_hit: cover property ($rose(secure_port_hit));
  c_err: cover property (acc && pslverr);
endmodule
bind gpls_port gpls_port_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pslverr, .pad_in, .pad_oe, .periph_own, .periph_oe, .periph_in,
  .nonsecure_port_hit, .secure_port_hit, .wake_hit);

// ### test/gpls_port_tb.sv
`timescale 1ns/1ps
`include "gpls_consts.vh"
module gpls_port_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] level = 32'h0;
  logic [31:0] own = 32'h0;
  logic [31:0] rd;
  wire [31:0] prdata, pad_in, pad_out, pad_oe, periph_in;
  wire pready, pslverr, ns_hit, s_hit, wake_hit;
  int errors = 0;
  int n_compared = 0;
  initial forever #2.5 pclk = ~pclk;
  // Override inputs share one vector so each owned pin drives high
  gpls_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .periph_own(own), .periph_out(own),
    .periph_oe(own), .periph_in, .nonsecure_port_hit(ns_hit), .secure_port_hit(s_hit),
    .wake_hit);
  gpls_pads pads (.pclk, .level, .pad_out, .pad_oe, .pad_in);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Waits past k edges, then lets that edge's updates land
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // One APB transfer; an idle edge follows so psel never flips in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
    begin
      errors++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial
  begin
    tick(4);
    presetn <= 1'b1;
    tick(1);
    apb(0, 12'h204, 0);
    chk("config reset", rd, `GPLS_CFG_RESET);
    apb(0, 12'h100, 0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    apb(1, 12'h206, 32'h00030000);
    apb(0, 12'h204, 0);
    chk("misaligned ignored", rd, `GPLS_CFG_RESET);
    $display("test registers done");
    level <= 32'h28;
    apb(1, 12'h20C, 32'h0);
    tick(3);
    apb(0, `GPLS_OFF_IN, 0);
    chk("input", rd, 32'h8);
    chk("peripheral input", periph_in, 32'h8);
    $display("test input done");
    level <= 32'h0;
    tick(3);
    apb(1, 12'h20C, 32'h00020000);
    level <= 32'h8;
    tick(3);
    chk("direct hit", ns_hit, 32'h1);
    chk("wake", wake_hit, 32'h1);
    apb(1, `GPLS_OFF_CAPTURE, 32'h8);
    level <= 32'h0;
    tick(3);
    chk("hit off", ns_hit, 32'h0);
    apb(0, `GPLS_OFF_CAPTURE, 0);
    chk("flag kept", rd, 32'h8);
    apb(1, 12'h21C, 32'h00030000);
    tick(1);
    chk("level present", ns_hit, 32'h1);
    apb(1, 12'h21C, `GPLS_CFG_RESET);
    $display("test direct done");
    apb(1, `GPLS_OFF_NSMODE, 32'h1);
    tick(1);
    chk("latched", ns_hit, 32'h1);
    apb(1, `GPLS_OFF_CAPTURE, 32'h8);
    tick(1);
    chk("fresh edge", ns_hit, 32'h1);
    apb(1, `GPLS_OFF_CAPTURE, 32'h80);
    tick(1);
    chk("all clear", ns_hit, 32'h0);
    apb(1, `GPLS_OFF_NSMODE, 32'h0);
    $display("test latched done");
    apb(1, `GPLS_OFF_SECURE, 32'h8);
    level <= 32'h8;
    tick(3);
    chk("secure hit", {s_hit, ns_hit}, 32'h2);
    level <= 32'h0;
    own <= 32'h10;
    tick(3);
    chk("override", pad_oe & pad_out, 32'h10);
    apb(1, `GPLS_OFF_OUTSET, 32'h3);
    apb(1, `GPLS_OFF_DIRSET, 32'h1);
    chk("pad drive", {pad_oe[1:0], pad_out[1:0]}, 32'h7);
    $display("test secure and override done");
    report_and_stop();
  end
endmodule
